// >>> osc_source_select_switch_bench.sv
/*
  Self-checking bench of the clock source switch, driving its AHB-Lite slave.
  Assumes the switch answers with zero wait states and the oscillator model beside it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "oss_cfg.svh"
module osc_source_select_switch_bench;
  logic        clock, rst, hsel, hwrite, hreadyout, hresp;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize, mode_v;
  logic [31:0] hwdata, hrdata, v;
  logic        pin_out, pin_oe_n, pin_drv, pin_lvl, pa_data, pa_dir, pa_in;
  logic        run_en, stop_m, wait_m, brk, quad, dbl, int_en, rc_en, xt_en, ext_run;
  logic        int_clk, ext_clk, rc_clk, xt_clk, q_d, d_d, glitch_on;
  logic [7:0]  trim_bits;
  logic [31:0] trim_pat [3] = '{32'hFFFF_FFFF, 32'h0, 32'h5A};
  int          num_errors, num_checks, nq, nd, ne, ni, run, cyc;

  // The shared pin carries the switch's drive when enabled, else the bench's level.
  assign pin_lvl = !pin_oe_n ? pin_out : pin_drv;

  oss_switch oss_switch_i (
    .clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .internal_osc_clock(int_clk), .clock_input_pin(ext_clk), .rc_osc_clock(rc_clk),
    .crystal_clock(xt_clk), .clock_output_pin_in(pin_lvl),
    .clock_output_pin_out(pin_out), .clock_output_pin_oe_n(pin_oe_n),
    .port_a_bit_four_data(pa_data), .port_a_bit_four_dir(pa_dir),
    .port_a_bit_four_in(pa_in), .osc_run_enable(run_en),
    .monitor_bypass_mode(mode_v[0]), .test_mode_a(mode_v[1]), .test_mode_b(mode_v[2]),
    .stop_mode(stop_m), .wait_mode(wait_m), .break_state(brk),
    .quad_rate_clock(quad), .double_rate_clock(dbl), .trim_factor_bits(trim_bits),
    .internal_osc_enable(int_en), .rc_osc_enable(rc_en), .crystal_osc_enable(xt_en)
  );

  oss_osc_model oss_osc_model_i (
    .int_en(int_en), .rc_en(rc_en), .xtal_en(xt_en), .ext_run(ext_run),
    .int_clk(int_clk), .ext_clk(ext_clk), .rc_clk(rc_clk), .xtal_clk(xt_clk)
  );

  // The 25 MHz system clock.
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One bus transfer: address phase held until ready, then data phase until ready.
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : xfer

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0, q);
  endtask : rd

  task automatic wt(input int n);
    repeat (n) @(posedge clock);
  endtask : wt

  // Clears the edge counters off the clock edge, then lets a window pass.
  task automatic meas(input int n);
    @(negedge clock);
    nq = 0;
    nd = 0;
    ne = 0;
    ni = 0;
    wt(n);
  endtask : meas

  // Counts generated clock rises and checks quad pulse widths while armed.
  always @(posedge clock) begin
    if (quad === 1'b1 && q_d === 1'b0) nq++;
    if (dbl === 1'b1 && d_d === 1'b0) nd++;
    if (quad !== q_d) begin
      if (glitch_on) chk("quad pulse short", run < 2, 0);
      run = 0;
    end
    run++;
    q_d = quad;
    d_d = dbl;
  end
  always @(posedge ext_clk) ne++;
  always @(posedge int_clk) ni++;

  // A hang is cut short after a cycle ceiling well above the run length.
  always @(posedge clock) begin
    cyc++;
    if (cyc == 40000) begin
      num_errors++;
      summarize();
    end
  end

  initial begin
    {rst, hsel, hwrite, haddr, htrans, hwdata} = {1'b1, 48'h0};
    {pin_drv, pa_data, pa_dir, stop_m, wait_m, brk, ext_run, glitch_on} = 8'h0;
    {q_d, d_d, mode_v, run_en, hsize} = {5'h0, 1'b1, 3'h2};
    wt(3);
    rst <= 1'b0;
    rd(`OSS_TRIM_OFFSET, v);
    chk("trim reset", v, 32'h80);
    chk("trim bits", trim_bits, 8'h80);
    rd(`OSS_STATUS_OFFSET, v);
    chk("status reset", v, 32'h0);
    rd(12'h100, v);
    chk("unmapped", v, 32'h0);
    chk("hresp", hresp, 1'b0);
    $display("test reset done");
    // Software copies a trim byte; both ends of the range are tried.
    foreach (trim_pat[i]) begin
      wr(`OSS_TRIM_OFFSET, trim_pat[i]);
      rd(`OSS_TRIM_OFFSET, v);
      chk("trim rw", v, trim_pat[i] & 32'hFF);
    end
    @(negedge clock);
    chk("trim bits", trim_bits, 8'h5A);
    wr(`OSS_STATUS_OFFSET, 32'h1);
    rd(`OSS_STATUS_OFFSET, v);
    chk("engaged ro", v, 32'h0);
    $display("test trim done");
    // Crystal precharge drives the pin high as a port output first.
    pa_dir <= 1'b1;
    pa_data <= 1'b1;
    wt(8);
    @(negedge clock);
    chk("pin port drive", {pin_oe_n, pin_out}, 2'h1);
    @(posedge clock);
    pa_dir <= 1'b0;
    pin_drv <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      wr(`OSS_CONFIG_OFFSET, 32'h4 | s);
      wt(8);
      @(negedge clock);
      chk("pin oe_n", pin_oe_n, s == 1);
      chk("rc enable", rc_en, s == 2);
      chk("crystal enable", xt_en, s == 3);
      if (s == 1) chk("port input", pa_in, 1'b1);
      if (s == 3) chk("crystal pin", pin_out, 1'b1);
    end
    @(posedge clock);
    run_en <= 1'b0;
    wt(4);
    @(negedge clock);
    chk("enables off", {int_en, xt_en}, 2'h0);
    @(posedge clock);
    run_en <= 1'b1;
    $display("test pin done");
    // The enable is refused in each blocking mode and with the internal select.
    ext_run <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      mode_v <= (m < 3) ? 3'h1 << m : 3'h0;
      wr(`OSS_CONFIG_OFFSET, (m < 3) ? 32'h1 : 32'h0);
      wr(`OSS_STATUS_OFFSET, 32'h2);
      wt(60);
      rd(`OSS_STATUS_OFFSET, v);
      chk("status refused", v, 32'h2);
      wr(`OSS_STATUS_OFFSET, 32'h0);
    end
    mode_v <= 3'h0;
    $display("test refuse done");
    // Switch to the external clock with the source first held still.
    ext_run <= 1'b0;
    glitch_on <= 1'b1;
    wr(`OSS_CONFIG_OFFSET, 32'h1);
    wt(40);
    wr(`OSS_STATUS_OFFSET, 32'h2);
    wt(60);
    rd(`OSS_STATUS_OFFSET, v);
    chk("no edges", v, 32'h2);
    chk("internal kept", int_en, 1'b1);
    ext_run <= 1'b1;
    for (int k = 0; k < 80 && v[0] !== 1'b1; k++) rd(`OSS_STATUS_OFFSET, v);
    chk("engaged", v, 32'h3);
    @(negedge clock);
    chk("internal stopped", int_en, 1'b0);
    @(posedge clock);
    wait_m <= 1'b1;
    brk <= 1'b1;
    meas(1000);
    chk("quad follows ext", nq > 50 && nq - ne <= 2 && ne - nq <= 2, 1);
    chk("double half", nd * 2 - nq <= 2 && nq - nd * 2 <= 2, 1);
    glitch_on <= 1'b0;
    stop_m <= 1'b1;
    wt(8);
    meas(200);
    chk("stop halts", nq + nd, 0);
    {stop_m, wait_m, brk, ext_run} <= 4'h0;
    wt(100);
    rd(`OSS_STATUS_OFFSET, v);
    chk("no fallback", {v[0], int_en}, 2'h2);
    $display("test switch done");
    // A second reset restores the internal source and the trim default.
    rst <= 1'b1;
    wt(3);
    rst <= 1'b0;
    rd(`OSS_TRIM_OFFSET, v);
    chk("trim reset", v, 32'h80);
    rd(`OSS_STATUS_OFFSET, v);
    chk("status reset", v, 32'h0);
    chk("internal on", int_en, 1'b1);
    meas(700);
    chk("quad follows int", nq > 50 && nq - ni <= 2 && ni - nq <= 2, 1);
    $display("test rereset done");
    summarize();
  end
endmodule : osc_source_select_switch_bench
`default_nettype wire

// >>> oss_cfg.svh
/*
  Constants of the clock source select and switch block: register offsets,
  field positions, reset values and counts.
  Assumes inclusion by bare name from the package and the design module.
*/
`ifndef OSS_CFG_SVH
`define OSS_CFG_SVH

// Byte addresses on the register bus.
`define OSS_TRIM_OFFSET     12'h038
`define OSS_STATUS_OFFSET   12'h03C
`define OSS_CONFIG_OFFSET   12'h040

// Reset values.
`define OSS_TRIM_RESET      8'h80
`define OSS_CONFIG_RESET    3'h0

// Field positions in the status and configuration words.
`define OSS_ST_ENGAGED_BIT  0
`define OSS_ST_ENABLE_BIT   1
`define OSS_CF_SEL_LSB      0
`define OSS_CF_SEL_MSB      1
`define OSS_CF_PINCLK_BIT   2

// Rising edges of the external source needed before switching.
`define OSS_EDGE_COUNT      2'h2

`endif

// >>> oss_osc_model.sv
/*
  Behavioural model of the oscillator sources that feed the clock switch.
  Assumes the enables come from the switch and the external run control from the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module oss_osc_model (
  input  wire logic int_en,
  input  wire logic rc_en,
  input  wire logic xtal_en,
  input  wire logic ext_run,
  output logic      int_clk,
  output logic      ext_clk,
  output logic      rc_clk,
  output logic      xtal_clk
);
  // All sources start low and stand still while stopped.
  initial begin
    int_clk = 1'b0;
    ext_clk = 1'b0;
    rc_clk = 1'b0;
    xtal_clk = 1'b0;
  end
  always #203 int_clk = int_en ? ~int_clk : 1'b0;
  always #287 rc_clk = rc_en ? ~rc_clk : 1'b0;
  always #331 xtal_clk = xtal_en ? ~xtal_clk : 1'b0;
  // The external clock is started and stopped by the bench, never by the switch.
  always #251 ext_clk = ext_run ? ~ext_clk : 1'b0;
endmodule : oss_osc_model
`default_nettype wire

// >>> oss_pkg.sv
/*
  Types of the clock source select and switch block.
  Assumes the constants header is available for inclusion.
*/
`include "oss_cfg.svh"

package oss_pkg;

  // Source codes as held in the two select bits.
  typedef enum logic [1:0] {
    SRC_INTERNAL = 2'h0,
    SRC_EXTCLK   = 2'h1,
    SRC_RC       = 2'h2,
    SRC_CRYSTAL  = 2'h3
  } oss_src_t;

  // Switch sequencer states, one-hot.
  typedef enum logic [3:0] {
    ST_INT   = 4'h1,
    ST_EDGES = 4'h2,
    ST_ALIGN = 4'h4,
    ST_EXT   = 4'h8
  } oss_state_t;

endpackage : oss_pkg

// >>> oss_switch.sv
/*
  Clock source select and glitch-free switch with its AHB-Lite register slave.
  Assumes all source clocks and the shared pin arrive asynchronously and are
  sampled on the 25 MHz system clock; mode inputs come from logic on that clock.
*/
// The AHB-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "oss_cfg.svh"

// Overview of operation
// [RULE1] Trim register returns to hexadecimal 80 on every reset.
// [RULE2] Trim value steers the internal oscillator period around the midpoint.
// [RULE3] Software may copy the factory trim byte into the trim register.
// [RULE4] Two select bits choose internal, external clock, RC or crystal.
// [RULE5] Software programs the select bits and waits before enabling.
// [RULE6] Software may precharge a crystal by driving the output pin high.
// [RULE7] Two rising edges of the external source are counted before switching.
// [RULE8] The move to the external source makes no glitch or short pulse.
// [RULE9] Engaged status sets first; the internal oscillator stops afterwards.
// [RULE10] Internal oscillator returns only on reset; no fallback monitoring.
// [RULE11] External generator enable is read-write and cleared by reset.
// [RULE12] Enable is ignored in monitor bypass and both test modes.
// [RULE13] Engaged status is read-only, one while an external source drives.
// [RULE14] External clock mode uses the input pin directly, halved for double rate.
// [RULE15] Shared pin function follows source and pin clock output enable.
// [RULE16] Quad-rate clock equals the selected source clock.
// [RULE17] Double-rate clock runs at half the quad-rate frequency.
// [RULE18] Oscillator run enable switches the selected oscillator on or off.
// [RULE19] Wait mode leaves both generated clocks running.
// [RULE20] Stop mode halts the source and both generated clocks.
// [RULE21] Debug break state leaves both generated clocks running.
// [RULE22] After reset the internal oscillator drives until a switch completes.
// [RULE23] Enable is registered in the sampling domain before edges are counted.
module oss_switch (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        internal_osc_clock,
  input  wire logic        clock_input_pin,
  input  wire logic        rc_osc_clock,
  input  wire logic        crystal_clock,
  input  wire logic        clock_output_pin_in,
  output logic             clock_output_pin_out,
  output logic             clock_output_pin_oe_n,
  input  wire logic        port_a_bit_four_data,
  input  wire logic        port_a_bit_four_dir,
  output logic             port_a_bit_four_in,
  input  wire logic        osc_run_enable,
  input  wire logic        monitor_bypass_mode,
  input  wire logic        test_mode_a,
  input  wire logic        test_mode_b,
  input  wire logic        stop_mode,
  input  wire logic        wait_mode,
  input  wire logic        break_state,
  output logic             quad_rate_clock,
  output logic             double_rate_clock,
  output logic      [7:0]  trim_factor_bits,
  output logic             internal_osc_enable,
  output logic             rc_osc_enable,
  output logic             crystal_osc_enable
);

  localparam int NSRC = 5;

  logic [7:0]             internal_osc_trim_r;
  logic [7:0]             internal_osc_trim_nxt;
  logic                   ext_clock_gen_enable_r;
  logic                   ext_clock_gen_enable_nxt;
  logic [1:0]             clock_source_select_r;
  logic [1:0]             clock_source_select_nxt;
  logic                   pin_clock_out_enable_r;
  logic                   pin_clock_out_enable_nxt;
  logic                   ext_clock_engaged_r;
  logic                   ap_valid_r;
  logic                   ap_write_r;
  logic [11:0]            ap_addr_r;
  logic                   ap_take;
  logic [31:0]            rd_word;
  logic [NSRC-1:0]        raw_in;
  logic [NSRC-1:0]        s1_r;
  logic [NSRC-1:0]        s2_r;
  logic [NSRC-1:0]        s3_r;
  logic [NSRC-1:0]        filt_r;
  oss_pkg::oss_state_t    state_r;
  oss_pkg::oss_state_t    state_nxt;
  oss_pkg::oss_src_t      active_src_r;
  logic                   ext_filt;
  logic                   ext_prev_r;
  logic                   ext_rise;
  logic [1:0]             edge_cnt_r;
  logic                   enable_seen_r;
  logic                   mode_block;
  logic                   src_level;
  logic                   quad_nxt;
  logic                   pin_out_nxt;
  logic                   pin_oe_n_nxt;

  // Incoming source clocks and the shared pin as one vector for sampling.
  assign raw_in = {clock_output_pin_in, crystal_clock, rc_osc_clock,
                   clock_input_pin, internal_osc_clock};

  // Three-stage sampler per input; the filtered level moves when stages two and three agree.
  for (genvar i = 0; i < NSRC; i++) begin : g_sync
    always_ff @(posedge clock) begin
      if (rst) begin
        s1_r[i]   <= 1'b0;
        s2_r[i]   <= 1'b0;
        s3_r[i]   <= 1'b0;
        filt_r[i] <= 1'b0;
      end else begin
        s1_r[i] <= raw_in[i];
        s2_r[i] <= s1_r[i];
        s3_r[i] <= s2_r[i];
        if (s2_r[i] == s3_r[i]) begin
          filt_r[i] <= s3_r[i];
        end
      end
    end
  end

  // Address phase is taken when the bus is ready, this slave is selected and htrans[1] marks an active transfer.
  assign ap_take = hready & hsel & htrans[1];

  always_ff @(posedge clock) begin
    if (rst) begin
      ap_valid_r <= 1'b0;
      ap_write_r <= 1'b0;
      ap_addr_r  <= 12'h000;
    end else if (hready) begin
      ap_valid_r <= ap_take;
      ap_write_r <= hwrite;
      ap_addr_r  <= haddr;
    end
  end

  // Data-phase writes into the register next values; unmapped offsets are ignored.
  always_comb begin
    internal_osc_trim_nxt    = internal_osc_trim_r;
    ext_clock_gen_enable_nxt = ext_clock_gen_enable_r;
    clock_source_select_nxt  = clock_source_select_r;
    pin_clock_out_enable_nxt = pin_clock_out_enable_r;
    if (ap_valid_r && ap_write_r) begin
      unique case (ap_addr_r)
        // [RULE3] Factory trim copy.
        `OSS_TRIM_OFFSET: internal_osc_trim_nxt = hwdata[7:0];
        // [RULE11] Enable writable by software.
        `OSS_STATUS_OFFSET: ext_clock_gen_enable_nxt = hwdata[`OSS_ST_ENABLE_BIT];
        `OSS_CONFIG_OFFSET: begin
          clock_source_select_nxt  = hwdata[`OSS_CF_SEL_MSB:`OSS_CF_SEL_LSB];
          pin_clock_out_enable_nxt = hwdata[`OSS_CF_PINCLK_BIT];
        end
        default: ;
      endcase
    end
  end

  // [RULE1] Trim reset value.
  always_ff @(posedge clock) begin
    if (rst) begin
      internal_osc_trim_r <= `OSS_TRIM_RESET;
    end else begin
      internal_osc_trim_r <= internal_osc_trim_nxt;
    end
  end

  // [RULE11] Enable cleared by reset.
  always_ff @(posedge clock) begin
    if (rst) begin
      ext_clock_gen_enable_r <= 1'b0;
    end else begin
      ext_clock_gen_enable_r <= ext_clock_gen_enable_nxt;
    end
  end

  // [RULE4] Source select bits.
  always_ff @(posedge clock) begin
    if (rst) begin
      {pin_clock_out_enable_r, clock_source_select_r} <= `OSS_CONFIG_RESET;
    end else begin
      clock_source_select_r  <= clock_source_select_nxt;
      pin_clock_out_enable_r <= pin_clock_out_enable_nxt;
    end
  end

  // Read word built from next values, so a read right after a write sees the new data.
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (haddr)
      `OSS_TRIM_OFFSET: rd_word[7:0] = internal_osc_trim_nxt;
      `OSS_STATUS_OFFSET: begin
        // [RULE13] Engaged bit read-only.
        rd_word[`OSS_ST_ENGAGED_BIT] = ext_clock_engaged_r;
        rd_word[`OSS_ST_ENABLE_BIT]  = ext_clock_gen_enable_nxt;
      end
      `OSS_CONFIG_OFFSET: begin
        rd_word[`OSS_CF_SEL_MSB:`OSS_CF_SEL_LSB] = clock_source_select_nxt;
        rd_word[`OSS_CF_PINCLK_BIT]              = pin_clock_out_enable_nxt;
      end
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Read data is loaded at the address phase and stands through the data phase.
  always_ff @(posedge clock) begin
    if (rst) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      if (ap_take && !hwrite) begin
        hrdata <= rd_word;
      end
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // [RULE12] Enable ignored in monitor bypass or test modes.
  assign mode_block = monitor_bypass_mode | test_mode_a | test_mode_b;

  // [RULE23] Enable registered beside the sampled source before counting.
  always_ff @(posedge clock) begin
    if (rst) begin
      enable_seen_r <= 1'b0;
    end else begin
      enable_seen_r <= ext_clock_gen_enable_r & ~mode_block &
                       (clock_source_select_r != oss_pkg::SRC_INTERNAL);
    end
  end

  // Filtered level of the external source that is being brought in.
  always_comb begin
    unique case (active_src_r)
      oss_pkg::SRC_EXTCLK:  ext_filt = filt_r[1];
      oss_pkg::SRC_RC:      ext_filt = filt_r[2];
      oss_pkg::SRC_CRYSTAL: ext_filt = filt_r[3];
      default:              ext_filt = 1'b0;
    endcase
  end

  assign ext_rise = ext_filt & ~ext_prev_r;

  // Switch sequencer; only reset brings the internal source back.
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      oss_pkg::ST_INT: begin
        if (enable_seen_r) begin
          state_nxt = oss_pkg::ST_EDGES;
        end
      end
      oss_pkg::ST_EDGES: begin
        // [RULE7] Two rising edges counted.
        if (ext_rise && edge_cnt_r == `OSS_EDGE_COUNT - 2'h1) begin
          state_nxt = oss_pkg::ST_ALIGN;
        end
      end
      oss_pkg::ST_ALIGN: begin
        // [RULE8] Switch just after the external source falls, while both are low.
        // A fresh fall keeps the external level low for the next cycles as well.
        if (!filt_r[0] && ext_prev_r && !ext_filt && !quad_rate_clock) begin
          state_nxt = oss_pkg::ST_EXT;
        end
      end
      // [RULE10] No return without reset.
      oss_pkg::ST_EXT: state_nxt = oss_pkg::ST_EXT;
    endcase
  end

  // [RULE22] Internal source after reset.
  always_ff @(posedge clock) begin
    if (rst) begin
      state_r <= oss_pkg::ST_INT;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Source captured at the start of a switch and edge counting.
  always_ff @(posedge clock) begin
    if (rst) begin
      active_src_r <= oss_pkg::SRC_INTERNAL;
      edge_cnt_r   <= 2'h0;
      ext_prev_r   <= 1'b0;
    end else begin
      ext_prev_r <= ext_filt;
      if (state_r == oss_pkg::ST_INT) begin
        active_src_r <= oss_pkg::oss_src_t'(clock_source_select_r);
        edge_cnt_r   <= 2'h0;
      end else if (state_r == oss_pkg::ST_EDGES && ext_rise) begin
        edge_cnt_r <= edge_cnt_r + 2'h1;
      end
    end
  end

  // [RULE9] Engaged sets on entry to external; internal enable drops one cycle later.
  always_ff @(posedge clock) begin
    if (rst) begin
      ext_clock_engaged_r <= 1'b0;
    end else begin
      ext_clock_engaged_r <= (state_nxt == oss_pkg::ST_EXT);
    end
  end

  // [RULE18] Run enable gates the selected oscillator.
  always_ff @(posedge clock) begin
    if (rst) begin
      internal_osc_enable <= 1'b1;
      rc_osc_enable       <= 1'b0;
      crystal_osc_enable  <= 1'b0;
    end else begin
      internal_osc_enable <= osc_run_enable & ~stop_mode & ~ext_clock_engaged_r;
      rc_osc_enable       <= osc_run_enable & ~stop_mode &
                             (clock_source_select_r == oss_pkg::SRC_RC);
      crystal_osc_enable  <= osc_run_enable & ~stop_mode &
                             (clock_source_select_r == oss_pkg::SRC_CRYSTAL);
    end
  end

  // [RULE14] External source used directly once engaged.
  assign src_level = ext_clock_engaged_r ? ext_filt : filt_r[0];

  // [RULE20] Stop holds the quad clock low; wait and break do not touch it.
  // [RULE19] [RULE21] Wait and break pass.
  assign quad_nxt = src_level & ~stop_mode & osc_run_enable;

  // [RULE16] Quad-rate clock follows the source.
  always_ff @(posedge clock) begin
    if (rst) begin
      quad_rate_clock <= 1'b0;
    end else begin
      quad_rate_clock <= quad_nxt;
    end
  end

  // [RULE17] Double-rate clock toggles on each quad rising edge.
  always_ff @(posedge clock) begin
    if (rst) begin
      double_rate_clock <= 1'b0;
    end else if (quad_nxt && !quad_rate_clock) begin
      double_rate_clock <= ~double_rate_clock;
    end
  end

  // [RULE2] Trim value handed to the internal oscillator.
  always_ff @(posedge clock) begin
    if (rst) begin
      trim_factor_bits <= `OSS_TRIM_RESET;
    end else begin
      trim_factor_bits <= internal_osc_trim_r;
    end
  end

  // [RULE15] Shared pin function by source and pin clock output enable.
  always_comb begin
    pin_out_nxt  = port_a_bit_four_data;
    pin_oe_n_nxt = ~port_a_bit_four_dir;
    unique case (oss_pkg::oss_src_t'(clock_source_select_r))
      oss_pkg::SRC_CRYSTAL: begin
        pin_out_nxt  = ~filt_r[1];
        pin_oe_n_nxt = 1'b0;
      end
      oss_pkg::SRC_EXTCLK: ;
      default: begin
        if (pin_clock_out_enable_r) begin
          pin_out_nxt  = quad_nxt;
          pin_oe_n_nxt = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      clock_output_pin_out  <= 1'b0;
      clock_output_pin_oe_n <= 1'b1;
      port_a_bit_four_in    <= 1'b0;
    end else begin
      clock_output_pin_out  <= pin_out_nxt;
      clock_output_pin_oe_n <= pin_oe_n_nxt;
      port_a_bit_four_in    <= filt_r[4];
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_engage;
    $rose(ext_clock_engaged_r);
  endsequence

  sequence s_int_still_on;
    internal_osc_enable ##1 !internal_osc_enable;
  endsequence

  chk_engage_before_stop: assert property ( // RULE9
    s_engage and osc_run_enable && !stop_mode |-> s_int_still_on)
    else $error("Internal oscillator stopped before engaged status set.");

  chk_trim_reset_val: assert property ( // RULE1
    $past(rst) |-> internal_osc_trim_r == 8'h80)
    else $error("Trim register not 80 after reset.");

  chk_enable_reset_clr: assert property ( // RULE11
    $past(rst) |-> !ext_clock_gen_enable_r && !ext_clock_engaged_r)
    else $error("Enable or engaged not cleared by reset.");

  chk_engage_sticky: assert property ( // RULE10
    ext_clock_engaged_r |=> ext_clock_engaged_r)
    else $error("Engaged status fell without reset.");

  chk_edges_before_sw: assert property ( // RULE7
    $rose(ext_clock_engaged_r) |-> $past(edge_cnt_r) == 2'h2)
    else $error("Switch before two external edges.");

  chk_mode_blocks_en: assert property ( // RULE12
    mode_block |=> !enable_seen_r)
    else $error("Enable honoured in a blocked mode.");

  chk_stop_halts_clk: assert property ( // RULE20
    stop_mode [*2] |-> !quad_rate_clock && $stable(double_rate_clock))
    else $error("Clocks run in stop mode.");

  chk_no_glitch_sw: assert property ( // RULE8
    $rose(ext_clock_engaged_r) |-> !quad_rate_clock ##1 !quad_rate_clock)
    else $error("Quad clock high across the switch.");

  chk_double_half: assert property ( // RULE17
    $rose(quad_rate_clock) |-> double_rate_clock != $past(double_rate_clock))
    else $error("Double-rate clock missed a quad rising edge.");

  chk_pin_crystal: assert property ( // RULE15
    clock_source_select_r == 2'h3 && $stable(clock_source_select_r)
      |=> !clock_output_pin_oe_n)
    else $error("Pin not driven in crystal mode.");

  chk_wait_brk_run: assert property ( // RULE19 RULE21
    (wait_mode || break_state) && osc_run_enable && !stop_mode
      |=> quad_rate_clock == $past(src_level))
    else $error("Quad clock held in wait or break state.");

endmodule : oss_switch

`default_nettype wire
